/* hw/rfc_cfg.svh */
`ifndef RFC_CFG_SVH
`define RFC_CFG_SVH
// Register power-on values
`define RFC_RST_STATUS      16'h0000
`define RFC_RST_GENCFG      16'h8008
`define RFC_RST_FREQCORR    16'hc4f7
`define RFC_RST_TXCFG       16'h9800
`define RFC_RST_TXBYTE      16'hb8aa
`define RFC_RST_CARRIER     16'ha680
`define RFC_RST_RXCFG       16'h9080
`define RFC_RST_BBFILT      16'hc22c
`define RFC_RST_RXFIFO      16'hb000
`define RFC_RST_FIFORST     16'hca80
`define RFC_RST_SYNCPAT     16'hced4
`define RFC_RST_BITRATE     16'hc623
`define RFC_RST_PWRMGT      16'h8208
`define RFC_RST_WAKETMR     16'he196
`define RFC_RST_DUTYCYC     16'hc80e
`define RFC_RST_BATTCLK     16'hc000
`define RFC_RST_PLLCFG      16'hcc77
// Software reset command word
`define RFC_CMD_SOFT_RESET  16'hfe00
// Field positions
`define RFC_FRM_RESET_MODE  0
`define RFC_FRM_FILL_LSB    4
// Timing
`define RFC_CLK_MHZ         200
`define RFC_SOFT_RST_NS     250000
`define RFC_SOFT_RST_CYC    ((`RFC_SOFT_RST_NS * `RFC_CLK_MHZ) / 1000)
`endif

/* hw/rfc_pkg.sv */
`default_nettype none
package rfc_pkg;
   typedef logic [15:0] rfc_word_t;
   typedef enum logic [4:0] {
      RFC_R_GENCFG   = 5'h00,
      RFC_R_FREQCORR = 5'h01,
      RFC_R_TXCFG    = 5'h02,
      RFC_R_TXBYTE   = 5'h03,
      RFC_R_CARRIER  = 5'h04,
      RFC_R_RXCFG    = 5'h05,
      RFC_R_BBFILT   = 5'h06,
      RFC_R_FIFORST  = 5'h07,
      RFC_R_SYNCPAT  = 5'h08,
      RFC_R_BITRATE  = 5'h09,
      RFC_R_PWRMGT   = 5'h0a,
      RFC_R_WAKETMR  = 5'h0b,
      RFC_R_DUTYCYC  = 5'h0c,
      RFC_R_BATTCLK  = 5'h0d,
      RFC_R_PLLCFG   = 5'h0e,
      RFC_R_STATUS   = 5'h0f,
      RFC_R_RXFIFO   = 5'h10,
      RFC_R_SOFTRST  = 5'h11,
      RFC_R_NONE     = 5'h1f
   } rfc_reg_e;
   typedef enum logic [1:0] {
      RFC_ST_RUN  = 2'b00,
      RFC_ST_HOLD = 2'b01,
      RFC_ST_SOFT = 2'b10
   } rfc_rst_e;
endpackage
`default_nettype wire

/* hw/rfc_spi_rx.sv */
`default_nettype none
module rfc_spi_rx
   import rfc_pkg::*;
(
   input  wire logic       i_ref_clk,   // System clock
   input  wire logic       i_rst_n,     // Sync reset, active low
   input  wire logic       i_block,     // Discard words
   input  wire logic       i_sel_n,     // Serial select, active low
   input  wire logic       i_sck,       // Serial clock, sampled
   input  wire logic       i_sdi,       // Serial data in
   output logic            o_word_vld,  // Full word pulse
   output rfc_word_t       o_word       // Received word
);
   typedef struct packed {
      logic      sck_d;
      logic [4:0] cnt;
      rfc_word_t sh;
      logic      vld;
      rfc_word_t word;
   } rfc_spi_s;
   rfc_spi_s r, next_r;

   always_comb begin
      next_r     = r;
      next_r.vld = 1'b0;
      next_r.sck_d = i_sck;
      if (i_sel_n || i_block) begin
         next_r.cnt = 5'h00;
      end else if (i_sck && !r.sck_d) begin
         next_r.sh = {r.sh[14:0], i_sdi};
         if (r.cnt == 5'd15) begin
            // Act only on a complete word
            next_r.vld  = 1'b1;
            next_r.word = {r.sh[14:0], i_sdi};
            next_r.cnt  = 5'h00;
         end else begin
            next_r.cnt = r.cnt + 5'd1;
         end
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign o_word_vld = r.vld;
   assign o_word     = r.word;

   chk_word_needs_sel: assert property (@(posedge i_ref_clk)
      disable iff (!i_rst_n) o_word_vld |-> !$past(i_sel_n))
      else $error("word completed without select");
endmodule // rfc_spi_rx
`default_nettype wire

/* hw/rfc_decode.sv */
`default_nettype none
`include "rfc_cfg.svh"
module rfc_decode
   import rfc_pkg::*;
(
   input  wire rfc_word_t i_word,   // Command word
   output rfc_reg_e       o_reg     // Target register
);
   // Command code prefixes select the register
   always_comb begin
      o_reg = RFC_R_NONE;
      if (i_word == `RFC_CMD_SOFT_RESET)           o_reg = RFC_R_SOFTRST;
      else if (i_word[15:13] == 3'b111)            o_reg = RFC_R_WAKETMR;
      else if (i_word[15:12] == 4'ha)              o_reg = RFC_R_CARRIER;
      else if (i_word[15:11] == 5'b1_0010)         o_reg = RFC_R_RXCFG;
      else if (i_word[15:9]  == 7'b1_0011_00)      o_reg = RFC_R_TXCFG;
      else if (i_word[15:8] == 8'h00) o_reg = RFC_R_STATUS;
      else begin
         unique case (i_word[15:8])
            8'h80:   o_reg = RFC_R_GENCFG;
            8'hc4:   o_reg = RFC_R_FREQCORR;
            8'hb8:   o_reg = RFC_R_TXBYTE;
            8'hc2:   o_reg = RFC_R_BBFILT;
            8'hb0:   o_reg = RFC_R_RXFIFO;
            8'hca:   o_reg = RFC_R_FIFORST;
            8'hce:   o_reg = RFC_R_SYNCPAT;
            8'hc6:   o_reg = RFC_R_BITRATE;
            8'h82:   o_reg = RFC_R_PWRMGT;
            8'hc8:   o_reg = RFC_R_DUTYCYC;
            8'hc0:   o_reg = RFC_R_BATTCLK;
            8'hcc:   o_reg = RFC_R_PLLCFG;
            default: o_reg = RFC_R_NONE;
         endcase
      end
   end
endmodule // rfc_decode
`default_nettype wire

/* hw/rfc_ctrl_regs.sv */
// Notes on behaviour
// - Four reset sources: power-on, glitch, command, pin
// - Power-on restores all registers automatically
// - Commands discarded while any reset active
// - Glitch-sensitive mode default; bit0 selects normal
// - Every reset re-enables glitch-sensitive mode
// - Word FE00 resets only in sensitive mode
// - Software reset restores values, lasts 0.25 ms
// - Active-low open-drain reset pin resets registers
// - Command code bits select register, rest payload
// - Status flags from bit 15, zero after reset except bit 14, set by power-on
// - Power management low byte holds block enables
// - Fifo/reset register low byte field layout
`default_nettype none
`include "rfc_cfg.svh"
module rfc_ctrl_regs
   import rfc_pkg::*;
#(
   parameter int unsigned SOFT_RST_CYC = `RFC_SOFT_RST_CYC
) (
   input  wire logic  i_ref_clk,      // 200 MHz clock
   input  wire logic  i_rst_n,        // Sync reset, active low
   input  wire logic  i_por,          // Supply power-on event
   input  wire logic  i_glitch,       // Supply glitch detected
   input  wire logic  i_rst_pin,      // Reset pin level in
   output logic       o_rst_pin,      // Reset pin drive value
   output logic       o_rst_pin_oe,   // Reset pin drive enable
   input  wire logic  i_sel_n,        // Serial select, low
   input  wire logic  i_sck,          // Serial clock
   input  wire logic  i_sdi,          // Serial data in
   output logic       o_sdo,          // Serial data out
   input  wire logic  i_fifo_svc,     // Fifo service event
   input  wire logic  i_fifo_ovr,     // Fifo overrun event
   input  wire logic  i_wake_irq,     // Wake timer event
   input  wire logic [7:0] i_rx_data, // Received fifo byte
   output logic       o_in_reset,     // Any reset active
   output logic       o_sensitive,    // Sensitive mode, FE00 armed
   output rfc_word_t  o_status,       // Status word view
   output logic [7:0] o_pwr_en,       // Block enables
   output logic [3:0] o_fill_count,   // Fifo fill count
   output logic [3:0] o_fifo_ctl,     // Sync/fill bits, mode
   output rfc_word_t  o_gencfg,       // General config
   output rfc_word_t  o_freqcorr,     // Frequency correction
   output rfc_word_t  o_txcfg,        // Transmit config
   output rfc_word_t  o_txbyte,       // Transmit byte
   output rfc_word_t  o_carrier,      // Carrier frequency
   output rfc_word_t  o_rxcfg,        // Receive config
   output rfc_word_t  o_bbfilt,       // Baseband filter
   output rfc_word_t  o_syncpat,      // Sync pattern
   output rfc_word_t  o_bitrate,      // Bit rate
   output rfc_word_t  o_waketmr,      // Wake timer
   output rfc_word_t  o_dutycyc,      // Duty cycle
   output rfc_word_t  o_battclk,      // Battery and clock
   output rfc_word_t  o_pllcfg        // Synth loop config
);
   localparam logic [16:0] SOFT_LAST = 17'(SOFT_RST_CYC - 1);

   typedef struct packed {
      rfc_rst_e    st;
      logic        sck_d;
      logic [16:0] cnt;
      logic        por_flag;
      logic        svc_flag;
      logic        ovr_flag;
      logic        wake_flag;
      rfc_word_t   sh_out;
      rfc_word_t   gencfg, freqcorr, txcfg, txbyte, carrier, rxcfg;
      rfc_word_t   bbfilt, fiforst, syncpat, bitrate, pwrmgt;
      rfc_word_t   waketmr, dutycyc, battclk, pllcfg;
   } rfc_ctl_s;
   rfc_ctl_s r, next_r;

   logic      word_vld;
   rfc_word_t word;
   rfc_reg_e  target;
   logic      hw_reset;
   logic      block;
   logic      rd_status;

   // ************************************************
   // Reset sources
   // ************************************************
   // Pin is open drain: never driven high, sensed only
   assign o_rst_pin    = 1'b0;
   assign o_rst_pin_oe = 1'b0;
   assign hw_reset = i_por || i_glitch || !i_rst_pin;
   assign block    = hw_reset || (r.st != RFC_ST_RUN);

   // ************************************************
   // Serial receive and decode
   // ************************************************
   rfc_spi_rx u_spi (
      .i_ref_clk  (i_ref_clk),
      .i_rst_n    (i_rst_n),
      .i_block    (block),
      .i_sel_n    (i_sel_n),
      .i_sck      (i_sck),
      .i_sdi      (i_sdi),
      .o_word_vld (word_vld),
      .o_word     (word)
   );

   rfc_decode u_dec (
      .i_word (word),
      .o_reg  (target)
   );

   assign rd_status = word_vld && !block && (target == RFC_R_STATUS);

   // ************************************************
   // Register update
   // ************************************************
   always_comb begin
      next_r = r;
      next_r.sck_d = i_sck;
      // Set wins over clear on status flags
      if (rd_status) begin
         next_r.por_flag  = 1'b0;
         next_r.svc_flag  = 1'b0;
         next_r.ovr_flag  = 1'b0;
         next_r.wake_flag = 1'b0;
      end
      if (i_fifo_svc) next_r.svc_flag  = 1'b1;
      if (i_fifo_ovr) next_r.ovr_flag  = 1'b1;
      if (i_wake_irq) next_r.wake_flag = 1'b1;
      if (i_sel_n) begin
         next_r.sh_out = '0;
      end else if (!i_sck && r.sck_d) begin
         next_r.sh_out = {r.sh_out[14:0], 1'b0};
      end
      unique case (r.st)
         RFC_ST_RUN: begin
            if (word_vld && !hw_reset) begin
               unique case (target)
                  RFC_R_GENCFG:   next_r.gencfg   = word;
                  RFC_R_FREQCORR: next_r.freqcorr = word;
                  RFC_R_TXCFG:    next_r.txcfg    = word;
                  RFC_R_TXBYTE:   next_r.txbyte   = word;
                  RFC_R_CARRIER:  next_r.carrier  = word;
                  RFC_R_RXCFG:    next_r.rxcfg    = word;
                  RFC_R_BBFILT:   next_r.bbfilt   = word;
                  RFC_R_FIFORST:  next_r.fiforst  = word;
                  RFC_R_SYNCPAT:  next_r.syncpat  = word;
                  RFC_R_BITRATE:  next_r.bitrate  = word;
                  RFC_R_PWRMGT:   next_r.pwrmgt   = word;
                  RFC_R_WAKETMR:  next_r.waketmr  = word;
                  RFC_R_DUTYCYC:  next_r.dutycyc  = word;
                  RFC_R_BATTCLK:  next_r.battclk  = word;
                  RFC_R_PLLCFG:   next_r.pllcfg   = word;
                  RFC_R_STATUS: begin
                     next_r.sh_out = o_status;
                  end
                  RFC_R_RXFIFO: begin
                     next_r.sh_out = {8'h00, i_rx_data};
                  end
                  RFC_R_SOFTRST: begin
                     // Only armed in sensitive mode
                     if (!r.fiforst[`RFC_FRM_RESET_MODE]) begin
                        next_r.st  = RFC_ST_SOFT;
                        next_r.cnt = '0;
                     end
                  end
                  default: ;
               endcase
            end
         end
         RFC_ST_HOLD: begin
            if (!hw_reset) next_r.st = RFC_ST_RUN;
         end
         RFC_ST_SOFT: begin
            if (r.cnt == SOFT_LAST) begin
               next_r.st = RFC_ST_RUN;
            end else begin
               next_r.cnt = r.cnt + 17'd1;
            end
         end
         default: next_r.st = RFC_ST_HOLD;
      endcase
      // All resets reload power-on values
      if (hw_reset || next_r.st == RFC_ST_SOFT) begin
         next_r.gencfg   = `RFC_RST_GENCFG;
         next_r.freqcorr = `RFC_RST_FREQCORR;
         next_r.txcfg    = `RFC_RST_TXCFG;
         next_r.txbyte   = `RFC_RST_TXBYTE;
         next_r.carrier  = `RFC_RST_CARRIER;
         next_r.rxcfg    = `RFC_RST_RXCFG;
         next_r.bbfilt   = `RFC_RST_BBFILT;
         next_r.fiforst  = `RFC_RST_FIFORST;
         next_r.syncpat  = `RFC_RST_SYNCPAT;
         next_r.bitrate  = `RFC_RST_BITRATE;
         next_r.pwrmgt   = `RFC_RST_PWRMGT;
         next_r.waketmr  = `RFC_RST_WAKETMR;
         next_r.dutycyc  = `RFC_RST_DUTYCYC;
         next_r.battclk  = `RFC_RST_BATTCLK;
         next_r.pllcfg   = `RFC_RST_PLLCFG;
         next_r.svc_flag  = 1'b0;
         next_r.ovr_flag  = 1'b0;
         next_r.wake_flag = 1'b0;
         next_r.por_flag  = 1'b0;
         next_r.sh_out    = '0;
      end
      if (hw_reset) begin
         next_r.st = RFC_ST_HOLD;
      end
      if (i_por) next_r.por_flag = 1'b1;
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         r          <= '0;
         r.st       <= RFC_ST_HOLD;
         r.gencfg   <= `RFC_RST_GENCFG;
         r.freqcorr <= `RFC_RST_FREQCORR;
         r.txcfg    <= `RFC_RST_TXCFG;
         r.txbyte   <= `RFC_RST_TXBYTE;
         r.carrier  <= `RFC_RST_CARRIER;
         r.rxcfg    <= `RFC_RST_RXCFG;
         r.bbfilt   <= `RFC_RST_BBFILT;
         r.fiforst  <= `RFC_RST_FIFORST;
         r.syncpat  <= `RFC_RST_SYNCPAT;
         r.bitrate  <= `RFC_RST_BITRATE;
         r.pwrmgt   <= `RFC_RST_PWRMGT;
         r.waketmr  <= `RFC_RST_WAKETMR;
         r.dutycyc  <= `RFC_RST_DUTYCYC;
         r.battclk  <= `RFC_RST_BATTCLK;
         r.pllcfg   <= `RFC_RST_PLLCFG;
      end else begin
         r <= next_r;
      end
   end

   // ************************************************
   // Outputs
   // ************************************************
   assign o_status = {r.svc_flag, r.por_flag, r.ovr_flag, r.wake_flag,
                      12'h000};
   assign o_sdo        = r.sh_out[15];
   assign o_in_reset   = block;
   assign o_sensitive  = !r.fiforst[`RFC_FRM_RESET_MODE];
   assign o_pwr_en     = r.pwrmgt[7:0];
   assign o_fill_count = r.fiforst[`RFC_FRM_FILL_LSB +: 4];
   assign o_fifo_ctl   = r.fiforst[3:0];
   assign o_gencfg     = r.gencfg;
   assign o_freqcorr   = r.freqcorr;
   assign o_txcfg      = r.txcfg;
   assign o_txbyte     = r.txbyte;
   assign o_carrier    = r.carrier;
   assign o_rxcfg      = r.rxcfg;
   assign o_bbfilt     = r.bbfilt;
   assign o_syncpat    = r.syncpat;
   assign o_bitrate    = r.bitrate;
   assign o_waketmr    = r.waketmr;
   assign o_dutycyc    = r.dutycyc;
   assign o_battclk    = r.battclk;
   assign o_pllcfg     = r.pllcfg;

   // ************************************************
   // Checks
   // ************************************************
   sequence soft_cmd_s;
      word_vld && !block && target == RFC_R_SOFTRST && o_sensitive;
   endsequence

   chk_pin_resets_regs: assert property (@(posedge i_ref_clk)
      disable iff (!i_rst_n) !i_rst_pin |=> r.pwrmgt == `RFC_RST_PWRMGT
      && r.fiforst == `RFC_RST_FIFORST)
      else $error("pin reset left registers changed");
   chk_por_restores: assert property (@(posedge i_ref_clk)
      disable iff (!i_rst_n) i_por |=> r.gencfg == `RFC_RST_GENCFG
      && r.por_flag)
      else $error("power-on did not restore");
   chk_reset_blocks: assert property (@(posedge i_ref_clk)
      disable iff (!i_rst_n) block |=> $stable(r.txbyte)
      || r.txbyte == `RFC_RST_TXBYTE)
      else $error("write accepted during reset");
   chk_soft_enters: assert property (@(posedge i_ref_clk)
      disable iff (!i_rst_n) (soft_cmd_s and !hw_reset) |=>
      r.st == RFC_ST_SOFT && r.fiforst == `RFC_RST_FIFORST)
      else $error("soft reset not started");
   chk_soft_ignored: assert property (@(posedge i_ref_clk)
      disable iff (!i_rst_n) word_vld && !block && !hw_reset
      && target == RFC_R_SOFTRST && !o_sensitive |=> r.st == RFC_ST_RUN)
      else $error("soft reset in normal mode");
   chk_soft_length: assert property (@(posedge i_ref_clk)
      disable iff (!i_rst_n) r.st == RFC_ST_SOFT && r.cnt == SOFT_LAST
      && !hw_reset |=> r.st == RFC_ST_RUN)
      else $error("soft reset length wrong");
   chk_sensitive_rearm: assert property (@(posedge i_ref_clk)
      disable iff (!i_rst_n) hw_reset |=> o_sensitive)
      else $error("sensitive mode not rearmed");
   chk_hold_last_src: assert property (@(posedge i_ref_clk)
      disable iff (!i_rst_n) hw_reset |=> o_in_reset)
      else $error("left reset early");
   chk_status_order: assert property (@(posedge i_ref_clk)
      disable iff (!i_rst_n) i_fifo_svc && !hw_reset
      |=> o_status[15] || r.st == RFC_ST_SOFT)
      else $error("service flag lost");
   chk_normal_mode: assert property (@(posedge i_ref_clk)
      disable iff (!i_rst_n) word_vld && !block && !hw_reset
      && target == RFC_R_FIFORST && word[0] |=> !o_sensitive)
      else $error("normal mode not taken");
endmodule // rfc_ctrl_regs
`default_nettype wire

/* verif/rfc_host_model.sv */
`default_nettype none
module rfc_host_model (
   input  wire logic i_ref_clk,  // Device clock
   output logic      o_sel_n,    // Serial select, low
   output logic      o_sck,      // Serial clock
   output logic      o_sdi,      // Serial data
   output logic      o_pin_low   // Pulls reset pin low
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      o_sel_n   = 1'b1;
      o_sck     = 1'b0;
      o_sdi     = 1'b0;
      o_pin_low = 1'b0;
   end
   // Command code leads, MSB first; n below 16 is a cut word
   task automatic send_bits(input logic [15:0] w, input int n);
      @(negedge i_ref_clk);
      o_sel_n = 1'b0;
      for (int i = 15; i > 15 - n; i--) begin
         @(negedge i_ref_clk);
         o_sck = 1'b0;
         o_sdi = w[i];
         @(negedge i_ref_clk);
         o_sck = 1'b1;
      end
      @(negedge i_ref_clk);
      o_sck = 1'b0;
      o_sdi = ~o_sdi;
      @(negedge i_ref_clk);
      o_sel_n = 1'b1;
      repeat (4) @(negedge i_ref_clk);
   endtask
   task automatic pin_hold(input logic low);
      @(negedge i_ref_clk);
      o_pin_low = low;
   endtask
endmodule // rfc_host_model
`default_nettype wire

/* verif/rf_ctrl_register_reset_bench.sv */
`default_nettype none
module rf_ctrl_register_reset_bench;
   import rfc_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int SOFT_CYC = 20;
   typedef struct packed {
      rfc_word_t wr;
      rfc_word_t por;
   } rfc_row_s;
   localparam rfc_row_s ROWS [15] = '{
      '{16'h80a5, 16'h8008}, '{16'hc45a, 16'hc4f7}, '{16'h9855, 16'h9800},
      '{16'hb83c, 16'hb8aa}, '{16'ha123, 16'ha680}, '{16'h9012, 16'h9080},
      '{16'hc2ac, 16'hc22c}, '{16'hce5a, 16'hced4}, '{16'hc6a7, 16'hc623},
      '{16'he234, 16'he196}, '{16'hc8f1, 16'hc80e}, '{16'hc0e5, 16'hc000},
      '{16'hcc57, 16'hcc77}, '{16'h82a5, 16'h8208}, '{16'hca51, 16'hca80}};
   logic       clk, rst_n, por, glitch, svc, ovr, wake;
   logic       sel_n, sck, sdi, pin_low, pin_lvl, pin_out, pin_oe;
   logic       in_reset, sensitive;
   logic       sdo, sdo_seen;
   logic [7:0] pwr_en;
   logic [3:0] fill_count, fifo_ctl;
   rfc_word_t  status, gencfg, freqcorr, txcfg, txbyte, carrier, rxcfg;
   rfc_word_t  bbfilt, syncpat, bitrate, waketmr, dutycyc, battclk, pllcfg;
   int         num_errors = 0;
   int         n_tests = 0;
   int         cycles = 0;
   // Open drain pin with pull-up
   assign pin_lvl = (pin_low || (pin_oe && !pin_out)) ? 1'b0 : 1'b1;
   rfc_host_model rfc_host_model_inst (.i_ref_clk(clk), .o_sel_n(sel_n),
      .o_sck(sck), .o_sdi(sdi), .o_pin_low(pin_low));
   rfc_ctrl_regs #(.SOFT_RST_CYC(SOFT_CYC)) rfc_ctrl_regs_inst (
      .i_ref_clk(clk), .i_rst_n(rst_n), .i_por(por), .i_glitch(glitch),
      .i_rst_pin(pin_lvl), .o_rst_pin(pin_out), .o_rst_pin_oe(pin_oe),
      .i_sel_n(sel_n), .i_sck(sck), .i_sdi(sdi), .o_sdo(sdo),
      .i_fifo_svc(svc), .i_fifo_ovr(ovr), .i_wake_irq(wake),
      .i_rx_data(8'h00), .o_in_reset(in_reset), .o_sensitive(sensitive),
      .o_status(status), .o_pwr_en(pwr_en), .o_fill_count(fill_count),
      .o_fifo_ctl(fifo_ctl), .o_gencfg(gencfg), .o_freqcorr(freqcorr),
      .o_txcfg(txcfg), .o_txbyte(txbyte), .o_carrier(carrier),
      .o_rxcfg(rxcfg), .o_bbfilt(bbfilt), .o_syncpat(syncpat),
      .o_bitrate(bitrate), .o_waketmr(waketmr), .o_dutycyc(dutycyc),
      .o_battclk(battclk), .o_pllcfg(pllcfg));
   always #2.5 clk = ~clk;
   // Remembers any high bit on the serial output
   always @(negedge clk) begin
      if (sdo === 1'b1) begin
         sdo_seen <= 1'b1;
      end
   end
   function automatic rfc_word_t get_out(input int k);
      case (k)
         0: return gencfg;
         1: return freqcorr;
         2: return txcfg;
         3: return txbyte;
         4: return carrier;
         5: return rxcfg;
         6: return bbfilt;
         7: return syncpat;
         8: return bitrate;
         9: return waketmr;
         10: return dutycyc;
         11: return battclk;
         12: return pllcfg;
         13: return {8'h82, pwr_en};
         default: return {8'hca, fill_count, fifo_ctl};
      endcase
   endfunction
   task automatic check(input string nm, input logic [15:0] exp,
                        input logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic check_por();
      for (int k = 0; k < 15; k++) begin
         check("power-on value", ROWS[k].por, get_out(k));
      end
   endtask
   // Bounded wait for the reset state to end
   task automatic wait_run();
      for (int i = 0; i < 10 * SOFT_CYC && in_reset !== 1'b0; i++) begin
         @(negedge clk);
      end
      check("reset ends", 16'h0000, {15'h0000, in_reset});
      repeat (4) @(negedge clk);
   endtask
   task automatic print_verdict();
      $display("Counts: %0d checks, %0d errors", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 10000) begin
         num_errors++;
         print_verdict();
      end
   end
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      {clk, rst_n, por, glitch, svc, ovr, wake} = 7'h00;
      sdo_seen = 1'b0;
      repeat (12) @(negedge clk);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      check_por();
      check("status", 16'h0000, status);
      check("sensitive", 16'h0001, {15'h0000, sensitive});
      $display("test reset_values done");
      for (int k = 0; k < 15; k++) begin
         rfc_host_model_inst.send_bits(ROWS[k].wr, 16);
         check("register", ROWS[k].wr, get_out(k));
      end
      check("normal mode", 16'h0000, {15'h0000, sensitive});
      $display("test table_writes done");
      rfc_host_model_inst.send_bits(16'hfe00, 16);
      check("soft refused", 16'h0000, {15'h0000, in_reset});
      check("gencfg kept", 16'h80a5, gencfg);
      rfc_host_model_inst.send_bits(16'hca80, 16);
      rfc_host_model_inst.send_bits(16'hfe00, 16);
      check("soft active", 16'h0001, {15'h0000, in_reset});
      wait_run();
      check_por();
      $display("test soft_reset done");
      svc = 1'b1;
      @(negedge clk);
      svc = 1'b0;
      ovr = 1'b1;
      wake = 1'b1;
      @(negedge clk);
      {ovr, wake} = 2'b00;
      @(negedge clk);
      check("status flags", 16'hb000, status);
      check("sdo idle", 16'h0000, {15'h0000, sdo_seen});
      rfc_host_model_inst.send_bits(16'h0000, 16);
      check("status cleared", 16'h0000, status);
      check("sdo status bit", 16'h0001, {15'h0000, sdo_seen});
      $display("test status done");
      rfc_host_model_inst.send_bits(16'hca51, 16);
      glitch = 1'b1;
      repeat (3) @(negedge clk);
      check("glitch reset", 16'h0001, {15'h0000, in_reset});
      rfc_host_model_inst.send_bits(16'h80ff, 16);
      glitch = 1'b0;
      wait_run();
      check("discarded", 16'h8008, gencfg);
      check("rearmed", 16'h0001, {15'h0000, sensitive});
      $display("test glitch done");
      rfc_host_model_inst.send_bits(16'h80a5, 16);
      rfc_host_model_inst.pin_hold(1'b1);
      por = 1'b1;
      repeat (3) @(negedge clk);
      rfc_host_model_inst.pin_hold(1'b0);
      repeat (3) @(negedge clk);
      check("overlap held", 16'h0001, {15'h0000, in_reset});
      check("pin released", 16'h0000, {15'h0000, pin_oe});
      por = 1'b0;
      wait_run();
      check("pin reset", 16'h8008, gencfg);
      $display("test pin_reset done");
      rfc_host_model_inst.send_bits(16'h80ff, 12);
      check("cut word", 16'h8008, gencfg);
      rfc_host_model_inst.send_bits(16'h80ff, 16);
      check("whole word", 16'h80ff, gencfg);
      $display("test partial done");
      print_verdict();
   end
endmodule // rf_ctrl_register_reset_bench
`default_nettype wire
